// file: design/sel_decoder.sv
// Purpose: decodes one four-bit selection field into a mode
// Assumes: pure combinational, caller registers the result
// Notes:   internal trigger only accepted when allow_int is set
`timescale 1ns/1ps
module sel_decoder (
  input  wire logic [3:0]              sel,
  input  wire logic                    allow_int,
  output tmr_io_pkg::decoded_type      dec
);
  import tmr_io_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // masked matches keep don't-care bits out of the decision
  always_comb begin
    dec.out_en     = 1'b0;
    dec.init_level = sel[2];
    dec.mode       = MODE_IDLE;
    if ((sel & MASK_INT) == CODE_CAP_INT) begin
      dec.mode = allow_int ? MODE_CAP_INT : MODE_IDLE;
    end else if ((sel & MASK_BOTH) == CODE_CAP_BOTH) begin
      dec.mode = MODE_CAP_BOTH;
    end else if (sel == CODE_CAP_FALL) begin
      dec.mode = MODE_CAP_FALL;
    end else if (sel == CODE_CAP_RISE) begin
      dec.mode = MODE_CAP_RISE;
    end else begin
      case (sel[1:0])
        2'h1: begin
          dec.out_en = 1'b1;
          dec.mode   = MODE_CMP_LOW;
        end
        2'h2: begin
          dec.out_en = 1'b1;
          dec.mode   = MODE_CMP_HIGH;
        end
        2'h3: begin
          dec.out_en = 1'b1;
          dec.mode   = MODE_CMP_TOG;
        end
        default: begin
          dec.mode = MODE_IDLE;
        end
      endcase
    end
  end

endmodule

// file: design/timer_channel_io_mode_select.sv
// Purpose: i/o mode selection for the ch3 b/c/d and ch4 b compare/capture registers
// Assumes: counters, compare matches and count strobes come from the timer core on clk
// Notes:   mode changes take effect at the next counter clock enable
//
// Notes on behaviour
// - code 1000 captures the counter on a rising pin edge.
// - code 1001 captures the counter on a falling pin edge.
// - code 101x captures on both pin edges, low bit ignored.
// - ch3 b and d: code 11xx takes trigger from ch4 counting.
// - ch3 b and d internal trigger captures whenever ch4 counter counts up or down, prescaler not 000.
// - ch4 prescaler 000 disables the ch4 count capture trigger.
// - ch3 d in buffer mode does neither capture nor compare.
// - ch4 b code 11xx captures on ch3 c match or capture.
// - code 0101 starts pin high, drives low at match; 0100 disabled.
// - code 0110 or 0010 drives pin high at match.
// - code 0111 or 0011 toggles pin at each match.
`timescale 1ns/1ps
module timer_channel_io_mode_select #(
  parameter int CNT_W = tmr_io_pkg::CNT_W_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire tmr_io_pkg::config_type  cfg,
  input  wire logic                    count_en,
  input  wire logic [CNT_W-1:0]        ch3_counter,
  input  wire logic [CNT_W-1:0]        ch4_counter,
  input  wire logic                    ch4_count_step,
  input  wire logic [3:0]              match_in,
  input  wire logic [3:0]              pin_in,
  output logic      [3:0]              pin_out,
  output logic      [3:0]              pin_oe,
  output logic      [3:0]              capture_stb,
  output logic      [CNT_W-1:0]        ch3_reg_b,
  output logic      [CNT_W-1:0]        ch3_reg_c,
  output logic      [CNT_W-1:0]        ch3_reg_d,
  output logic      [CNT_W-1:0]        ch4_reg_b
);
  import tmr_io_pkg::*;

  // ----------------------------------------------------------------
  // selection decode
  // ----------------------------------------------------------------
  logic [3:0]   sel_vec [NUM_UNITS];
  logic [3:0]   allow_int;
  decoded_type  dec_now [NUM_UNITS];
  decoded_type  dec_reg [NUM_UNITS];
  decoded_type  dec_next [NUM_UNITS];

  assign sel_vec[UNIT_B3] = cfg.sel_b3;
  assign sel_vec[UNIT_C3] = cfg.sel_c3;
  assign sel_vec[UNIT_D3] = cfg.sel_d3;
  assign sel_vec[UNIT_B4] = cfg.sel_b4;
  // only b3, d3 and b4 have an internal trigger source
  assign allow_int = 4'hd;

  // ----------------------------------------------------------------
  // pin synchronisers, three stages
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_next;
  logic [3:0] sync3_next;
  logic [3:0] level_reg;
  logic [3:0] level_next;

  // a change counts once stages two and three agree
  always_comb begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    level_next = level_reg;
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (sync2_reg[i] == sync3_reg[i]) begin
        level_next[i] = sync3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      level_reg <= 4'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      level_reg <= level_next;
    end
  end

  wire [3:0] rise = level_next & ~level_reg;
  wire [3:0] fall = ~level_next & level_reg;

  // ----------------------------------------------------------------
  // internal trigger sources
  // ----------------------------------------------------------------
  // an undivided ch4 clock would strobe every cycle, so it is ignored
  wire ch4_trig = ch4_count_step && (cfg.prescale_sel != PSC_UNDIVIDED);
  // ch3 c event for ch4 b: its compare match or its capture
  logic capture_stb_next_c3;
  wire c3_event = (match_in[UNIT_C3] && dec_reg[UNIT_C3].out_en) ||
                  capture_stb_next_c3;

  // ----------------------------------------------------------------
  // per unit logic
  // ----------------------------------------------------------------
  logic [3:0]        pin_out_next;
  logic [3:0]        pin_oe_next;
  logic [3:0]        cap_next;
  logic [CNT_W-1:0]  src_cnt [NUM_UNITS];
  logic [CNT_W-1:0]  cap_val_reg [NUM_UNITS];
  logic [CNT_W-1:0]  cap_val_next [NUM_UNITS];
  logic [3:0]        unit_off;

  assign src_cnt[UNIT_B3] = ch3_counter;
  assign src_cnt[UNIT_C3] = ch3_counter;
  assign src_cnt[UNIT_D3] = ch3_counter;
  assign src_cnt[UNIT_B4] = ch4_counter;
  // buffered d3 is neither capture nor compare
  assign unit_off = {1'b0, cfg.buffer_mode_d, 2'b00};
  assign capture_stb_next_c3 = cap_next[UNIT_C3];

  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : g_unit
      sel_decoder u_dec (
        .sel       (sel_vec[g]),
        .allow_int (allow_int[g]),
        .dec       (dec_now[g])
      );

      // trigger choice for this unit
      logic trig;
      always_comb begin
        trig = 1'b0;
        case (dec_reg[g].mode)
          MODE_CAP_RISE: trig = rise[g];
          MODE_CAP_FALL: trig = fall[g];
          MODE_CAP_BOTH: trig = rise[g] | fall[g];
          MODE_CAP_INT:  trig = (g == UNIT_B4) ? c3_event : ch4_trig;
          default:       trig = 1'b0;
        endcase
      end

      // next values: mode latched on counter clock, pin action on match
      always_comb begin
        dec_next[g]     = dec_reg[g];
        pin_out_next[g] = pin_out[g];
        pin_oe_next[g]  = pin_oe[g];
        cap_next[g]     = 1'b0;
        cap_val_next[g] = cap_val_reg[g];
        if (count_en) begin
          dec_next[g] = dec_now[g];
          if (dec_now[g].mode != dec_reg[g].mode ||
              dec_now[g].init_level != dec_reg[g].init_level) begin
            pin_out_next[g] = dec_now[g].init_level;
          end
        end
        pin_oe_next[g] = dec_next[g].out_en && !unit_off[g];
        if (!unit_off[g]) begin
          if (dec_reg[g].out_en && match_in[g]) begin
            case (dec_reg[g].mode)
              MODE_CMP_LOW:  pin_out_next[g] = 1'b0;
              MODE_CMP_HIGH: pin_out_next[g] = 1'b1;
              MODE_CMP_TOG:  pin_out_next[g] = ~pin_out[g];
              default:       pin_out_next[g] = pin_out[g];
            endcase
          end
          if (trig) begin
            cap_next[g]     = 1'b1;
            cap_val_next[g] = src_cnt[g];
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          dec_reg[g]     <= '{out_en: 1'b0, init_level: 1'b0, mode: MODE_IDLE};
          pin_out[g]     <= 1'b0;
          pin_oe[g]      <= 1'b0;
          capture_stb[g] <= 1'b0;
          cap_val_reg[g] <= '0;
        end else begin
          dec_reg[g]     <= dec_next[g];
          pin_out[g]     <= pin_out_next[g];
          pin_oe[g]      <= pin_oe_next[g];
          capture_stb[g] <= cap_next[g];
          cap_val_reg[g] <= cap_val_next[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // captured values out
  // ----------------------------------------------------------------
  assign ch3_reg_b = cap_val_reg[UNIT_B3];
  assign ch3_reg_c = cap_val_reg[UNIT_C3];
  assign ch3_reg_d = cap_val_reg[UNIT_D3];
  assign ch4_reg_b = cap_val_reg[UNIT_B4];

endmodule

// file: design/tmr_io_pkg.sv
// Purpose: shared constants and carriers for the timer channel i/o mode select block
// Assumes: four-bit selection fields, one system clock
// Notes:   mode codes are matched with don't-care bits masked
package tmr_io_pkg;

  // ----------------------------------------------------------------
  // selection field layout and codes
  // ----------------------------------------------------------------
  localparam int          SEL_W          = 4;
  localparam int          CNT_W_DEF      = 16;
  localparam int          PSC_W          = 3;
  localparam logic [3:0]  SEL_RESET      = 4'h0;
  localparam logic [3:0]  CODE_OFF0      = 4'h0;  // output disabled, initial 0
  localparam logic [3:0]  CODE_LOW0      = 4'h1;  // initial 0, 0 at match
  localparam logic [3:0]  CODE_HIGH0     = 4'h2;  // initial 0, 1 at match
  localparam logic [3:0]  CODE_TOG0      = 4'h3;  // initial 0, toggle at match
  localparam logic [3:0]  CODE_OFF1      = 4'h4;  // output disabled
  localparam logic [3:0]  CODE_LOW1      = 4'h5;  // initial 1, 0 at match
  localparam logic [3:0]  CODE_HIGH1     = 4'h6;  // initial 1, 1 at match
  localparam logic [3:0]  CODE_TOG1      = 4'h7;  // initial 1, toggle at match
  localparam logic [3:0]  CODE_CAP_RISE  = 4'h8;
  localparam logic [3:0]  CODE_CAP_FALL  = 4'h9;
  localparam logic [3:0]  CODE_CAP_BOTH  = 4'ha;  // matched under MASK_BOTH
  localparam logic [3:0]  MASK_BOTH      = 4'he;
  localparam logic [3:0]  CODE_CAP_INT   = 4'hc;  // matched under MASK_INT
  localparam logic [3:0]  MASK_INT       = 4'hc;
  localparam logic [2:0]  PSC_UNDIVIDED  = 3'h0;
  localparam int          NUM_UNITS      = 4;     // b3, c3, d3, b4
  localparam int          UNIT_B3        = 0;
  localparam int          UNIT_C3        = 1;
  localparam int          UNIT_D3        = 2;
  localparam int          UNIT_B4        = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IDLE, MODE_CMP_LOW, MODE_CMP_HIGH, MODE_CMP_TOG,
    MODE_CAP_RISE, MODE_CAP_FALL, MODE_CAP_BOTH, MODE_CAP_INT
  } mode_type;

  typedef struct packed {
    logic       out_en;
    logic       init_level;
    mode_type   mode;
  } decoded_type;

  typedef struct packed {
    logic [3:0] sel_b3;
    logic [3:0] sel_c3;
    logic [3:0] sel_d3;
    logic [3:0] sel_b4;
    logic       buffer_mode_d;
    logic [2:0] prescale_sel;
  } config_type;

endpackage

// file: verification/timer_channel_io_mode_select_monitor.sv
// Purpose: assertions on compare, capture and pin enable behaviour of the mode select block
// Assumes: selections are taken only on count_en, one clock domain
// Notes:   cfg_reg mirrors the latched selection so modes are judged as the block holds them
`timescale 1ns/1ps
module timer_channel_io_mode_select_monitor #(
  parameter int CNT_W = tmr_io_pkg::CNT_W_DEF
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire tmr_io_pkg::config_type cfg,
  input wire logic                   count_en,
  input wire logic [CNT_W-1:0]       ch3_counter,
  input wire logic [CNT_W-1:0]       ch4_counter,
  input wire logic                   ch4_count_step,
  input wire logic [3:0]             match_in,
  input wire logic [3:0]             pin_in,
  input wire logic [3:0]             pin_out,
  input wire logic [3:0]             pin_oe,
  input wire logic [3:0]             capture_stb,
  input wire logic [CNT_W-1:0]       ch3_reg_b,
  input wire logic [CNT_W-1:0]       ch4_reg_b
);
  import tmr_io_pkg::*;
  // ---------------------------------------------------------------
  // latched selection
  // ---------------------------------------------------------------
  config_type cfg_reg;
  config_type cfg_next;
  logic [3:0] b3;
  assign b3 = cfg_reg.sel_b3;
  // live cfg is ignored between count_en pulses
  always_comb cfg_next = count_en ? cfg : cfg_reg;
  always_ff @(posedge clk) begin
    cfg_reg <= rst_n ? cfg_next : '0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // checks; matches on a count_en cycle are skipped, the old mode's match action wins over the initial level there
  // ---------------------------------------------------------------
  low_match_a: assert property (
    b3 == 4'h5 && match_in[0] && !count_en |=> !pin_out[0]) else $error("b3 not low at match");
  high_match_a: assert property (
    !b3[3] && b3[1:0] == 2'b10 && match_in[0] && !count_en |=> pin_out[0])
    else $error("b3 not high at match");
  toggle_match_a: assert property (
    !b3[3] && b3[1:0] == 2'b11 && match_in[0] && !count_en |=> pin_out[0] != $past(pin_out[0]))
    else $error("b3 did not toggle");
  drive_enable_a: assert property (
    pin_oe[0] == (!b3[3] && b3[1:0] != 2'b00)) else $error("b3 output enable wrong");
  buffer_quiet_a: assert property (
    cfg_reg.buffer_mode_d && cfg.buffer_mode_d |-> !capture_stb[2] && !pin_oe[2])
    else $error("d3 active in buffer mode");
  count_capture_a: assert property (
    b3[3:2] == 2'b11 && cfg_reg.prescale_sel != 3'h0 && ch4_count_step
    |=> capture_stb[0] && ch3_reg_b == $past(ch3_counter)) else $error("b3 count capture missing");
  count_blocked_a: assert property (
    b3[3:2] == 2'b11 && cfg_reg.prescale_sel == 3'h0 |=> !capture_stb[0])
    else $error("b3 captured with undivided clock");
  rise_capture_a: assert property (
    b3 == 4'h8 && $rose(pin_in[0]) |-> ##[3:5] capture_stb[0]) else $error("no rise capture");
  fall_capture_a: assert property (
    b3 == 4'h9 && $fell(pin_in[0]) |-> ##[3:5] capture_stb[0]) else $error("no fall capture");
  both_capture_a: assert property (
    b3[3:1] == 3'b101 && $changed(pin_in[0]) |-> ##[3:5] capture_stb[0])
    else $error("no both-edge capture");
  linked_capture_a: assert property (
    cfg_reg.sel_b4[3:2] == 2'b11 && !cfg_reg.sel_c3[3] && cfg_reg.sel_c3[1:0] != 2'b00
    && match_in[1] && !count_en |=> capture_stb[3] && ch4_reg_b == $past(ch4_counter))
    else $error("b4 missed c3 match");
  cover property (capture_stb[3]);
  cover property (b3 == 4'ha && capture_stb[0]);
  cover property (cfg_reg.buffer_mode_d && pin_in[2]);
endmodule

bind timer_channel_io_mode_select timer_channel_io_mode_select_monitor #(.CNT_W(CNT_W)) mon_u (
  .clk(clk), .rst_n(rst_n), .cfg(cfg), .count_en(count_en), .ch3_counter(ch3_counter),
  .ch4_counter(ch4_counter), .ch4_count_step(ch4_count_step), .match_in(match_in),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .capture_stb(capture_stb),
  .ch3_reg_b(ch3_reg_b), .ch4_reg_b(ch4_reg_b));

// file: verification/timer_channel_io_mode_select_tb.sv
// Purpose: directed bench for compare, capture and linked trigger modes
// Assumes: inputs change 1 ns after the rising edge
// Notes:   counters are held still around pin edges, so capture values are exact
`timescale 1ns/1ps
module timer_channel_io_mode_select_tb;
  import tmr_io_pkg::*;
  localparam int CW = 16;
  logic            clk            = 1'b0;
  logic            rst_n          = 1'b0;
  config_type      cfg            = '0;
  logic            count_en       = 1'b0;
  logic            ch4_count_step = 1'b0;
  logic [CW-1:0]   ch3_counter    = 16'h1230;
  logic [CW-1:0]   ch4_counter    = 16'h5a5a;
  logic [3:0]      match_in       = 4'h0;
  logic [3:0]      pin_in         = 4'h0;
  logic [3:0]      pin_out, pin_oe, capture_stb, code;
  logic [CW-1:0]   ch3_reg_b, ch3_reg_c, ch3_reg_d, ch4_reg_b;
  int              fails          = 0;
  int              checks         = 0;
  int              cycles         = 0;
  always #20 clk = ~clk;
  timer_channel_io_mode_select #(.CNT_W(CW)) dut_u (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .count_en(count_en), .ch3_counter(ch3_counter),
    .ch4_counter(ch4_counter), .ch4_count_step(ch4_count_step), .match_in(match_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .capture_stb(capture_stb),
    .ch3_reg_b(ch3_reg_b), .ch3_reg_c(ch3_reg_c), .ch3_reg_d(ch3_reg_d), .ch4_reg_b(ch4_reg_b));
  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic chkv(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  // a selection only counts once count_en has carried it in
  task automatic set_cfg(input logic [3:0] b3, c3, d3, b4, input logic bd, input logic [2:0] ps);
    cfg = '{b3, c3, d3, b4, bd, ps};
    count_en = 1'b1;
    tick();
    count_en = 1'b0;
  endtask
  // eight cycles covers the pin synchroniser plus the capture itself
  task automatic pin_step(input int pb, input int sb, input logic v, input int want);
    int n;
    n = 0;
    pin_in[pb] = v;
    repeat (8) begin
      tick();
      if (capture_stb[sb] === 1'b1) n++;
    end
    chk1(n == want, 1'b1);
  endtask
  task automatic step_chk(input logic want);
    ch4_count_step = 1'b1;
    tick();
    ch4_count_step = 1'b0;
    chk1(capture_stb[0], want);
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, the whole run needs well under 600 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cfg.sel_b3 = 4'h5;
    tick();
    chk1(pin_oe[0], 1'b0);
    for (int c = 0; c < 8; c++) begin
      code = 4'(c);
      set_cfg(code, 4'h0, 4'h0, 4'h0, 1'b0, 3'h1);
      chk1(pin_oe[0], code[1:0] != 2'b00);
      if (code[1:0] != 2'b00) begin
        chk1(pin_out[0], code[2]);
        match_in[0] = 1'b1;
        tick();
        chk1(pin_out[0], code[1:0] == 2'b11 ? !code[2] : code[1]);
        tick();
        match_in[0] = 1'b0;
        chk1(pin_out[0], code[1:0] == 2'b11 ? code[2] : code[1]);
      end
    end
    set_cfg(4'h0, 4'h0, 4'h5, 4'h0, 1'b0, 3'h1);
    chk1(pin_oe[2], 1'b1);
    set_cfg(4'h0, 4'h0, 4'h8, 4'h0, 1'b1, 3'h1);
    pin_step(2, 2, 1'b1, 0);
    chk1(pin_oe[2], 1'b0);
    for (int c = 8; c < 12; c++) begin
      code = 4'(c);
      ch3_counter = 16'h1230 + 16'(c);
      set_cfg(code, 4'h0, 4'h0, 4'h0, 1'b0, 3'h1);
      pin_step(0, 0, 1'b1, int'(code != 4'h9));
      if (code != 4'h9) chkv(ch3_reg_b, 16'h1230 + 16'(c));
      pin_step(0, 0, 1'b0, int'(code != 4'h8));
    end
    ch3_counter = 16'h0abc;
    set_cfg(4'hf, 4'h0, 4'hc, 4'h0, 1'b0, 3'h1);
    step_chk(1'b1);
    chk1(capture_stb[2], 1'b1);
    chkv(ch3_reg_d, 16'h0abc);
    set_cfg(4'hc, 4'h0, 4'hc, 4'h0, 1'b0, 3'h0);
    step_chk(1'b0);
    set_cfg(4'h0, 4'h6, 4'h0, 4'hd, 1'b0, 3'h1);
    match_in[1] = 1'b1;
    tick();
    match_in[1] = 1'b0;
    chk1(capture_stb[3], 1'b1);
    chkv(ch4_reg_b, 16'h5a5a);
    ch4_counter = 16'h0f0f;
    set_cfg(4'h0, 4'h8, 4'h0, 4'hc, 1'b0, 3'h1);
    pin_step(1, 3, 1'b1, 1);
    chkv(ch4_reg_b, 16'h0f0f);
    chkv(ch3_reg_c, 16'h0abc);
    final_report();
  end
endmodule
